// ===== core/tick_timer_regs.vh
// Purpose: constants of the periodic tick timer
// Assumes: APB byte addressing, 32-bit data, one word per register
// Notes: the printed offset is taken as a word index; the byte address is four times it
`ifndef TICK_TIMER_REGS_VH
`define TICK_TIMER_REGS_VH

`define RTISC_INDEX 16'h1808
`define RTISC_ADDR 16'h6020
`define RTISC_RESET 8'h00
`define BIT_PEND 7
`define BIT_ACK 6
`define BIT_CLKSEL 5
`define BIT_IE 4
`define SEL_HI 2
`define SEL_LO 0
// 1 ms base time of the period ladder, in nanoseconds
`define BASE_TIME_NS 1000000
`define CLK_PERIOD_NS 5
`define BASE_CYCLES (`BASE_TIME_NS / `CLK_PERIOD_NS)
// one base tick is 1 ms of the selected source; counter reaches 128 ms
`define CNT_W 8

`endif

// ===== core/periodic_tick_timer.v
// Purpose: periodic tick timer with status and control register on APB
// Assumes: source ticks (internal oscillator, external clock) arrive as pulses
// Notes: external tick is a pin, synchronised before use
//        a period change acts on the running count, there is no restart
//        pending survives every reset except its own two clears
// Function
// (R01) whole register returns to zero on power-on reset and deep stop exit
// (R02) expiry in deep stop wakes the part, sets no flag or request
// (R03) timer expiry is a wake-up source from every power saving state
// (R04) in run or shallow stop, expiry sets the pending flag
// (R05) bit 7 reads pending; kept across the other kinds of reset
// (R06) writing 1 to bit 6 clears pending; bit 6 reads zero
// (R07) bit 5 picks source: 0 internal oscillator, 1 external clock
// (R08) bit 4 gates the interrupt request, zero after reset
// (R09) bits 2:0 pick period: off, 2, 4, 8, 16, 32, 64, 128 ms
// (R10) timer clock and counter value are outputs for other modules
// (R11) code 011 selects 8 ms
// (R12) request only when pending and enabled; bit 3 reads zero
`timescale 1ns/1ps
`include "tick_timer_regs.vh"

module periodic_tick_timer
(
	// clock and resets
	input wire CLOCK_I,
	input wire RESET_I,
	input wire DEEP_STOP_EXIT_I,
	// power mode
	input wire DEEP_STOP_MODE_I,
	input wire SHALLOW_STOP_MODE_I,
	// tick sources, 1 ms steps
	input wire OSC_TICK_I,
	input wire EXT_CLOCK_I,
	// apb slave
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire PWRITE_I,
	input wire [15:0] PADDR_I,
	input wire [31:0] PWDATA_I,
	input wire [3:0] PSTRB_I,
	output wire PREADY_O,
	output reg [31:0] PRDATA_O,
	output wire PSLVERR_O,
	// results
	output wire TICK_IRQ_O,
	output reg WAKEUP_O,
	output reg TICK_CLOCK_O,
	output reg [`CNT_W-1:0] TICK_COUNT_O
);

	function [`CNT_W-1:0] period_limit;
		input [2:0] sel;
		begin
			case (sel)
				3'h1: period_limit = 8'h02;
				3'h2: period_limit = 8'h04;
				// (R11) doubling gap
				3'h3: period_limit = 8'h08;
				3'h4: period_limit = 8'h10;
				3'h5: period_limit = 8'h20;
				3'h6: period_limit = 8'h40;
				3'h7: period_limit = 8'h80;
				default: period_limit = 8'h00;
			endcase
		end
	endfunction

	// synchroniser and edge detect of the external clock pin
	reg ext_meta_reg;
	reg ext_sync_reg;
	reg ext_last_reg;
	wire ext_rise;

	// register fields and their next values
	reg pend_reg;
	reg pend_next;
	reg pend_set;
	reg clksel_reg;
	reg clksel_next;
	reg ie_reg;
	reg ie_next;
	reg [2:0] sel_reg;
	reg [2:0] sel_next;

	// bus decode
	wire clear_all;
	wire setup;
	wire access;
	wire hit;
	wire lane0;
	wire wr_hit;
	wire ack_hit;
	reg [31:0] rdata_next;

	// period ladder
	genvar g;
	wire [7:0] sel_onehot;
	wire [`CNT_W-1:0] limit;
	wire running;

	// counting and wake, all settled by the combinational blocks below
	reg src_tick;
	reg expire;
	reg [`CNT_W-1:0] count_next;
	reg tick_clock_next;
	reg wake_next;

	// operating context of the part, decoded from the two mode levels;
	// deep stop takes precedence should both ever be high together
	localparam [1:0] MODE_RUN = 2'b00;
	localparam [1:0] MODE_SHALLOW = 2'b01;
	localparam [1:0] MODE_DEEP = 2'b10;

	function [1:0] mode_of;
		input deep;
		input shallow;
		begin
			if (deep)
				mode_of = MODE_DEEP;
			else if (shallow)
				mode_of = MODE_SHALLOW;
			else
				mode_of = MODE_RUN;
		end
	endfunction

	// software view of the register; bits 6 and 3 are never stored
	function [31:0] read_image;
		input pend;
		input clksel;
		input ie;
		input [2:0] sel;
		begin
			read_image = 32'h00000000;
			read_image[`BIT_PEND] = pend;
			read_image[`BIT_CLKSEL] = clksel;
			read_image[`BIT_IE] = ie;
			read_image[`SEL_HI:`SEL_LO] = sel;
		end
	endfunction

	// (R01) power-on reset and deep stop exit clear alike
	assign clear_all = RESET_I | DEEP_STOP_EXIT_I;
	assign setup = PSEL_I & ~PENABLE_I;
	assign access = PSEL_I & PENABLE_I;
	assign hit = (PADDR_I == `RTISC_ADDR);
	// only byte lane 0 carries the 8-bit register
	assign lane0 = PSTRB_I[0];
	assign wr_hit = access & PWRITE_I & hit & lane0;
	// (R06) acknowledge strobe
	assign ack_hit = wr_hit & PWDATA_I[`BIT_ACK];
	// no wait states: every access completes in one cycle
	assign PREADY_O = 1'b1;
	// unmapped addresses answer with an error, reads return zero
	assign PSLVERR_O = access & ~hit;

	// first stage read only by the second
	always @(posedge CLOCK_I)
	begin
		ext_meta_reg <= EXT_CLOCK_I;
		ext_sync_reg <= ext_meta_reg;
		ext_last_reg <= ext_sync_reg;
	end

	// rising edge of the synchronised pin
	assign ext_rise = ext_sync_reg & ~ext_last_reg;

	// one line per period code; code 0 is the off state
	generate
		for (g = 0; g < 8; g = g + 1)
		begin : sel_decode
			assign sel_onehot[g] = (sel_reg == g);
		end
	endgenerate

	// (R07) source choice
	// the pin path costs two cycles of lag, the oscillator none
	always @*
	begin
		case (clksel_reg)
			1'b0: src_tick = OSC_TICK_I;
			1'b1: src_tick = ext_rise;
			default: src_tick = 1'b0;
		endcase
	end

	// (R09) (R11) period ladder
	assign limit = period_limit(sel_reg);
	assign running = ~sel_onehot[0];

	// (R09) expiry on the tick that ends the period; a count left above a
	// newly shortened period ends on the next source tick instead of running on to 255
	always @*
	begin
		expire = 1'b0;
		if (running & src_tick)
			expire = (TICK_COUNT_O >= limit - 8'h01);
	end

	always @*
	begin
		count_next = TICK_COUNT_O;
		tick_clock_next = 1'b0;
		// off: counter parked at zero so a new period starts clean
		if (!running)
			count_next = 8'h00;
		else if (src_tick)
		begin
			tick_clock_next = 1'b1;
			if (expire)
				count_next = 8'h00;
			else
				count_next = TICK_COUNT_O + 8'h01;
		end
	end

	// (R10) counter for other modules
	always @(posedge CLOCK_I)
	begin
		if (clear_all)
			TICK_COUNT_O <= 8'h00;
		else
			TICK_COUNT_O <= count_next;
	end

	// (R10) one pulse per counted source tick, a clock enable for others
	always @(posedge CLOCK_I)
	begin
		if (clear_all)
			TICK_CLOCK_O <= 1'b0;
		else
			TICK_CLOCK_O <= tick_clock_next;
	end

	// (R07) (R08) (R09) control fields follow a write to the register
	always @*
	begin
		clksel_next = clksel_reg;
		ie_next = ie_reg;
		sel_next = sel_reg;
		// a read or a miss leaves the fields alone
		if (wr_hit)
		begin
			clksel_next = PWDATA_I[`BIT_CLKSEL];
			ie_next = PWDATA_I[`BIT_IE];
			sel_next = PWDATA_I[`SEL_HI:`SEL_LO];
		end
	end

	// (R01) control fields back to zero
	always @(posedge CLOCK_I)
	begin
		if (clear_all)
		begin
			clksel_reg <= 1'b0;
			ie_reg <= 1'b0;
			sel_reg <= 3'h0;
		end
		else
		begin
			clksel_reg <= clksel_next;
			ie_reg <= ie_next;
			sel_reg <= sel_next;
		end
	end

	// (R04) set in run or shallow stop; set wins over a same-cycle
	// acknowledge so that an expiry is never lost
	always @*
	begin
		case (mode_of(DEEP_STOP_MODE_I, SHALLOW_STOP_MODE_I))
			MODE_RUN: pend_set = expire;
			MODE_SHALLOW: pend_set = expire;
			// (R02) deep stop: expiry only wakes the part
			MODE_DEEP: pend_set = 1'b0;
			default: pend_set = 1'b0;
		endcase
		pend_next = pend_reg;
		if (pend_set)
			pend_next = 1'b1;
		// (R06) acknowledge by writing one
		else if (ack_hit)
			pend_next = 1'b0;
	end

	// (R05) only this block's own clears reach pending; other resets don't
	always @(posedge CLOCK_I)
	begin
		if (clear_all)
			pend_reg <= 1'b0;
		else
			pend_reg <= pend_next;
	end

	// (R02) (R03) wake from any stop mode, without flag in deep stop
	always @*
	begin
		case (mode_of(DEEP_STOP_MODE_I, SHALLOW_STOP_MODE_I))
			MODE_SHALLOW: wake_next = expire;
			MODE_DEEP: wake_next = expire;
			// nothing to wake from in run mode
			MODE_RUN: wake_next = 1'b0;
			default: wake_next = 1'b0;
		endcase
	end

	always @(posedge CLOCK_I)
	begin
		if (RESET_I)
			WAKEUP_O <= 1'b0;
		else
			WAKEUP_O <= wake_next;
	end

	// (R08) (R12) request needs pending and enable
	// level, drops the cycle after an acknowledge or a disable
	assign TICK_IRQ_O = pend_reg & ie_reg;

	// (R06) (R12) bits 6 and 3 read zero; other addresses read zero
	always @*
	begin
		rdata_next = PRDATA_O;
		if (setup)
		begin
			if (~PWRITE_I & hit)
				rdata_next = read_image(pend_reg, clksel_reg, ie_reg, sel_reg);
			else
				rdata_next = 32'h00000000;
		end
	end

	// read image is taken in the setup cycle and stands through access
	always @(posedge CLOCK_I)
	begin
		if (RESET_I)
			PRDATA_O <= 32'h00000000;
		else
			PRDATA_O <= rdata_next;
	end

endmodule // periodic_tick_timer

// ===== testbench/tick_timer_properties.sv
// Purpose: port checks of the tick timer
// Assumes: one clock, sync reset
// Notes: bound at the foot
`timescale 1ns/1ps
module tick_props(
	input wire CLOCK_I,
	input wire RESET_I,
	input wire DEEP_STOP_EXIT_I,
	input wire PSEL_I,
	input wire PENABLE_I,
	input wire [15:0] PADDR_I,
	input wire PSLVERR_O,
	input wire [31:0] PRDATA_O,
	input wire [7:0] TICK_COUNT_O,
	input wire TICK_CLOCK_O,
	input wire DEEP_STOP_MODE_I,
	input wire SHALLOW_STOP_MODE_I,
	input wire TICK_IRQ_O,
	input wire WAKEUP_O
);
default clocking @(posedge CLOCK_I); endclocking
default disable iff (RESET_I);
property p_clr; $past(RESET_I) |-> !TICK_IRQ_O; endproperty
a_clr: assert property (p_clr) else $error("request after reset");
property p_deep; $rose(TICK_IRQ_O) |-> !$past(DEEP_STOP_MODE_I) || $past(PSEL_I); endproperty
a_deep: assert property (p_deep) else $error("request in deep stop");
property p_wake; WAKEUP_O |-> $past(DEEP_STOP_MODE_I) || $past(SHALLOW_STOP_MODE_I); endproperty
a_wake: assert property (p_wake) else $error("wake in run");
property p_exit; DEEP_STOP_EXIT_I |=> !TICK_IRQ_O && TICK_COUNT_O == 8'h00; endproperty
a_exit: assert property (p_exit) else $error("state kept over deep stop exit");
property p_zero; !PRDATA_O[6] && !PRDATA_O[3]; endproperty
a_zero: assert property (p_zero) else $error("fixed zero bit reads one");
property p_err; PSEL_I && PENABLE_I && PADDR_I != 16'h6020 |-> PSLVERR_O; endproperty
a_err: assert property (p_err) else $error("unmapped access without error");
property p_tick;
	TICK_COUNT_O != 8'h00 && TICK_COUNT_O == $past(TICK_COUNT_O) + 8'h01 |-> TICK_CLOCK_O;
endproperty
a_tick: assert property (p_tick) else $error("count moved without tick");
c_wake: cover property (WAKEUP_O);
c_irq: cover property ($rose(TICK_IRQ_O));
c_deep: cover property (DEEP_STOP_MODE_I && WAKEUP_O);
endmodule // tick_props
bind periodic_tick_timer tick_props chk (.CLOCK_I(CLOCK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I),
	.DEEP_STOP_EXIT_I(DEEP_STOP_EXIT_I), .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I),
	.PSLVERR_O(PSLVERR_O), .PRDATA_O(PRDATA_O), .TICK_COUNT_O(TICK_COUNT_O),
	.TICK_CLOCK_O(TICK_CLOCK_O),
	.DEEP_STOP_MODE_I(DEEP_STOP_MODE_I), .SHALLOW_STOP_MODE_I(SHALLOW_STOP_MODE_I),
	.TICK_IRQ_O(TICK_IRQ_O), .WAKEUP_O(WAKEUP_O));

// ===== testbench/power_model.sv
// Purpose: power modes and oscillator
// Assumes: 10 cycles stand for 1 ms
// Notes: any wake returns to run
`timescale 1ns/1ps
module power_model(
	input wire clk,
	input wire stop_req,
	input wire deep_req,
	input wire wake,
	output reg deep = 0,
	output reg shallow = 0,
	output reg osc_tick = 0,
	output reg deep_exit = 0
);
integer n = 0;
always @(posedge clk)
begin
	n <= (n == 9) ? 0 : n + 1;
	osc_tick <= n == 9;
	// leaving deep stop clears the timer's register
	deep_exit <= wake & deep;
	if (wake)
	begin
		deep <= 0;
		shallow <= 0;
	end
	else if (stop_req)
	begin
		deep <= deep_req;
		shallow <= !deep_req;
	end
end
endmodule // power_model

// ===== testbench/tb_real_time_interrupt_timer.sv
// Purpose: tick timer bench
// Assumes: model in integers
// Notes: ext clock random, a 10-cycle square wave while xm is set
`timescale 1ns/1ps
`include "tick_timer_regs.vh"
module tb_real_time_interrupt_timer;
reg clk = 0, rst = 1, ps = 0, pe = 0, pw = 0, ex = 0, dx = 0, sr = 0, dr = 0, xm = 0, e = 0;
reg [31:0] wd = 0, r;
reg [15:0] pa = `RTISC_ADDR;
wire [31:0] rd;
wire rdy, er, irq, wk, dp, sh, ot, de;
integer seed = 48, failures = 0, comparisons = 0, cyc = 0, k, c;
initial forever #2.5 clk = ~clk;
periodic_tick_timer uut (.CLOCK_I(clk), .RESET_I(rst), .DEEP_STOP_EXIT_I(dx | de),
	.DEEP_STOP_MODE_I(dp), .SHALLOW_STOP_MODE_I(sh), .OSC_TICK_I(ot), .EXT_CLOCK_I(ex),
	.PSEL_I(ps), .PENABLE_I(pe), .PWRITE_I(pw), .PADDR_I(pa), .PWDATA_I(wd), .PSTRB_I(4'hf),
	.PREADY_O(rdy), .PRDATA_O(rd), .PSLVERR_O(er), .TICK_IRQ_O(irq), .WAKEUP_O(wk),
	.TICK_CLOCK_O(), .TICK_COUNT_O());
power_model pm (.clk(clk), .stop_req(sr), .deep_req(dr), .wake(wk), .deep(dp),
	.shallow(sh), .osc_tick(ot), .deep_exit(de));
task results;
begin
	$display("failures %0d comparisons %0d", failures, comparisons);
	if (failures == 0 && comparisons > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
end
endtask
task chk(input [31:0] g, input [31:0] x);
begin
	comparisons = comparisons + 1;
	if (g !== x)
	begin
		failures = failures + 1;
		$display("wrong value %0t %h %h", $time, g, x);
	end
end
endtask
task apb(input w, input [31:0] d);
begin
	@(posedge clk);
	ps <= 1;
	pw <= w;
	wd <= d;
	@(posedge clk);
	pe <= 1;
	@(posedge clk);
	while (rdy !== 1)
		@(posedge clk);
	r = rd;
	e = er;
	ps <= 0;
	pe <= 0;
end
endtask
// irq or wake, cycles counted in k
task wt(input s);
begin
	k = 0;
	do
	begin
		@(posedge clk);
		k = k + 1;
	end
	while ((s ? wk : irq) !== 1);
end
endtask
always @(posedge clk)
begin
	ex <= xm ? (cyc % 10 < 5) : $random(seed);
	cyc <= cyc + 1;
	if (cyc == 20000)
	begin
		failures = failures + 1;
		results;
	end
end
initial
begin
	repeat (12) @(posedge clk);
	rst <= 0;
	apb(0, 0);
	chk(r, `RTISC_RESET);
	c = $random(seed) & 32'hf8;
	apb(1, c);
	apb(0, 0);
	chk(r, c & 32'h30);
	pa <= 0;
	apb(0, 0);
	chk(e, 1);
	pa <= `RTISC_ADDR;
	for (c = 0; c < 2; c = c + 1)
	begin
		apb(1, 32'h51);
		wt(0);
		apb(1, 32'h51);
		sr <= 1;
		dr <= !c;
		wt(1);
		sr <= 0;
		@(posedge clk);
		chk(irq, c);
	end
	xm <= 1;
	apb(1, 32'h71);
	wt(0);
	apb(1, 32'h71);
	wt(0);
	chk(k + 3, 20);
	xm <= 0;
	for (c = 1; c < 8; c = c + 1)
	begin
		apb(1, 32'h50 | c);
		wt(0);
		apb(1, 32'h50 | c);
		wt(0);
		chk(k + 3, 10 << c);
	end
	dx <= 1;
	@(posedge clk);
	dx <= 0;
	apb(0, 0);
	chk(r, 0);
	results;
end
endmodule // tb_real_time_interrupt_timer
